// File: frw_top.sv
// Behaviour
// - mode bit picks thermal or current forecast
// - thermal mode uses protection model level
// - current mode warns after level exceeded past delay
// - level 20..200 percent, release at 90 percent
// - warning delay 0.1 to 60.0 seconds
// - speed display is frequency times A, clamped
// - controller display is value times (A-B) plus B
// - current and voltage display flicker filter
// - three skip frequencies with common band width
// - all skip frequencies zero disables skipping
// - no skipping while output is ramping
// - overlapping bands merge into one range, except a chain of three visited in reverse order
// - four step bits select fifteen presets
// - unassigned step bits read as zero
// - presets 0.00 to 400.00 Hz, 0.01 Hz
// - timed run enable off 0, on 1
// - timed run stops at stage time
// - run count cleared on stop or trip
// - independent analog offsets, -5.0 to +5.0 percent
// - shared analog filter 0.00 to 5.00 s
// - feedback input uses feedback filter instead
// - warning only for first motor set
`timescale 1ns/1ps
`default_nettype none

module frw_top #(
	parameter int TICK_CYCLES = frw_pkg::TICK_CYCLES
) (
	input  wire  logic        core_clk_i,
	input  wire  logic        sys_rst_i,
	input  wire  logic        psel_i,
	input  wire  logic        penable_i,
	input  wire  logic        pwrite_i,
	input  wire  logic [7:0]  paddr_i,
	input  wire  logic [31:0] pwdata_i,
	output logic       [31:0] prdata_o,
	output logic              pready_o,
	output logic              pslverr_o,
	input  wire  logic        step_select_bit0_i,
	input  wire  logic        step_select_bit1_i,
	input  wire  logic        step_select_bit2_i,
	input  wire  logic        step_select_bit3_i,
	input  wire  logic        run_cmd_i,
	input  wire  logic        trip_i,
	input  wire  logic        ramping_i,
	input  wire  logic [15:0] normal_ref_i,
	input  wire  logic [15:0] out_freq_i,
	input  wire  logic [11:0] out_current_i,
	input  wire  logic [11:0] thermal_level_i,
	input  wire  logic [15:0] out_voltage_i,
	input  wire  logic [10:0] analog_v_i,
	input  wire  logic [10:0] analog_i_i,
	input  wire  logic [13:0] pid_value_i,
	output logic       [15:0] freq_ref_o,
	output logic              overload_early_warning_o,
	output logic              auto_stop_o
);
	import frw_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic int clampi(input int v, input int lo, input int hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	// first-order step: y moves 1/n of the error per tick
	function automatic int lpf(input int x, input int y, input int n);
		if (n == 0) begin
			return x;
		end
		return y + (x - y) / n;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [5:0] pin_meta_reg;
	logic [5:0] pin_sync_reg;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pin_meta_reg <= 6'h00;
			pin_sync_reg <= 6'h00;
		end else begin
			pin_meta_reg <= {trip_i, run_cmd_i, step_select_bit3_i, step_select_bit2_i,
				step_select_bit1_i, step_select_bit0_i};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// settings registers
	// ------------------------------------------------------------
	logic [11:0] ctrl_reg;
	logic [7:0]  warn_level_reg;
	logic [9:0]  warn_delay_reg;
	logic [14:0] disp_a_reg;
	logic [14:0] disp_b_reg;
	logic [5:0]  disp_filt_reg;
	logic [8:0]  skip_reg [3];
	logic [4:0]  skip_bw_reg;
	logic [18:0] stage_time_reg;
	logic signed [7:0] ofs_v_reg;
	logic signed [7:0] ofs_i_reg;
	logic [8:0]  ana_filt_reg;
	logic [8:0]  fb_filt_reg;
	logic [15:0] preset_reg [PRESETS];

	logic        wr_en;
	int          preset_idx;
	int          wv;
	assign wr_en      = psel_i & penable_i & pready_o & pwrite_i;
	assign preset_idx = int'(paddr_i[7:2]) - int'(OFS_PRESET_0[7:2]);
	assign wv         = int'(pwdata_i[15:0]);

	// clamp writes so logic never sees illegal values
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ctrl_reg       <= 12'h000;
			warn_level_reg <= 8'(LEVEL_RST);
			warn_delay_reg <= 10'(DELAY_RST);
			disp_a_reg     <= 15'(SCALE_RST);
			disp_b_reg     <= 15'h0000;
			disp_filt_reg  <= 6'h00;
			skip_bw_reg    <= 5'h00;
			stage_time_reg <= 19'h00000;
			ofs_v_reg      <= 8'sh00;
			ofs_i_reg      <= 8'sh00;
			ana_filt_reg   <= 9'h000;
			fb_filt_reg    <= 9'h000;
			for (int k = 0; k < 3; k++) begin
				skip_reg[k] <= 9'h000;
			end
			for (int k = 0; k < PRESETS; k++) begin
				preset_reg[k] <= 16'h0000;
			end
		end else if (wr_en) begin
			if (paddr_i == OFS_CTRL) begin
				ctrl_reg <= pwdata_i[11:0] & CTRL_MASK;
			end else if (paddr_i == OFS_WARN_LEVEL) begin
				warn_level_reg <= 8'(clampi(wv, LEVEL_MIN, LEVEL_MAX));
			end else if (paddr_i == OFS_WARN_DELAY) begin
				warn_delay_reg <= 10'(clampi(wv, DELAY_MIN, DELAY_MAX));
			end else if (paddr_i == OFS_DISP_A) begin
				disp_a_reg <= 15'(clampi(wv, 0, SCALE_MAX));
			end else if (paddr_i == OFS_DISP_B) begin
				disp_b_reg <= 15'(clampi(wv, 0, SCALE_MAX));
			end else if (paddr_i == OFS_DISP_FILT) begin
				disp_filt_reg <= 6'(clampi(wv, 0, DISP_FILT_MAX));
			end else if (paddr_i == OFS_SKIP_1) begin
				skip_reg[0] <= 9'(clampi(wv, 0, SKIP_MAX));
			end else if (paddr_i == OFS_SKIP_2) begin
				skip_reg[1] <= 9'(clampi(wv, 0, SKIP_MAX));
			end else if (paddr_i == OFS_SKIP_3) begin
				skip_reg[2] <= 9'(clampi(wv, 0, SKIP_MAX));
			end else if (paddr_i == OFS_SKIP_BW) begin
				skip_bw_reg <= 5'(clampi(wv, 0, SKIP_BW_MAX));
			end else if (paddr_i == OFS_STAGE_TIME) begin
				stage_time_reg <= 19'(clampi(int'(pwdata_i[18:0]), 0, STAGE_MAX));
			end else if (paddr_i == OFS_ANA_OFS) begin
				ofs_v_reg <= 8'(clampi(int'($signed(pwdata_i[7:0])), -OFS_LIMIT, OFS_LIMIT));
				ofs_i_reg <= 8'(clampi(int'($signed(pwdata_i[15:8])), -OFS_LIMIT, OFS_LIMIT));
			end else if (paddr_i == OFS_ANA_FILT) begin
				ana_filt_reg <= 9'(clampi(wv, 0, ANA_FILT_MAX));
			end else if (paddr_i == OFS_FB_FILT) begin
				fb_filt_reg <= 9'(clampi(wv, 0, ANA_FILT_MAX));
			end else if (paddr_i >= OFS_PRESET_0 && paddr_i <= OFS_PRESET_END) begin
				preset_reg[preset_idx] <= 16'(clampi(wv, 0, PRESET_MAX));
			end
		end
	end

	// ------------------------------------------------------------
	// filter tick
	// ------------------------------------------------------------
	logic [31:0] tick_cnt_reg;
	logic        tick_reg;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			tick_cnt_reg <= 32'h00000000;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 32'h00000000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
			tick_reg     <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// step selection and skip bands
	// ------------------------------------------------------------
	logic [3:0]  step_code;
	logic [15:0] target;
	int          skip_out;
	assign step_code = pin_sync_reg[3:0] & ctrl_reg[CTRL_ASSIGN_LSB +: 4];
	assign target    = (step_code == 4'h0) ? normal_ref_i : preset_reg[int'(step_code) - 1];

	// merged excluded range; two passes cover any chain of two bands, but a chain of three visited in reverse order needs a third
	always_comb begin
		int f;
		int lo;
		int hi;
		int blo;
		int bhi;
		logic hit;
		f   = int'(target);
		lo  = f;
		hi  = f;
		hit = 1'b0;
		blo = 0;
		bhi = 0;
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 3; k++) begin
				blo = (int'(skip_reg[k]) - int'(skip_bw_reg)) * HZ_TO_CHZ;
				bhi = (int'(skip_reg[k]) + int'(skip_bw_reg)) * HZ_TO_CHZ;
				if (skip_reg[k] != 9'h000 && blo <= hi && bhi >= lo && (hit || (f > blo && f < bhi))) begin
					hit = 1'b1;
					lo  = (blo < lo) ? blo : lo;
					hi  = (bhi > hi) ? bhi : hi;
				end
			end
		end
		// stick to the edge we came from
		if (!hit || ramping_i) begin
			skip_out = f;
		end else if (int'(freq_ref_o) >= hi) begin
			skip_out = hi;
		end else begin
			skip_out = clampi(lo, 0, PRESET_MAX);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			freq_ref_o <= 16'h0000;
		end else begin
			freq_ref_o <= 16'(skip_out);
		end
	end

	// ------------------------------------------------------------
	// overload early warning
	// ------------------------------------------------------------
	frw_warn_t warn_state_reg;
	logic [9:0]  warn_cnt_reg;
	logic [3:0]  warn_sub_reg;
	logic [11:0] monitored;
	logic        over_level;
	logic        released;
	assign monitored  = ctrl_reg[CTRL_WARN_MODE] ? out_current_i : thermal_level_i;
	assign over_level = int'(monitored) > int'(warn_level_reg) * PCT_TO_PERMIL;
	assign released   = int'(monitored) * 100 <= int'(warn_level_reg) * PCT_TO_PERMIL * RELEASE_PCT;

	// thermal mode fires at once, the model already integrates over time
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || ctrl_reg[CTRL_MOTOR2]) begin
			warn_state_reg <= WARN_IDLE;
			warn_cnt_reg   <= 10'h000;
			warn_sub_reg   <= 4'h0;
		end else begin
			case (warn_state_reg)
				WARN_IDLE: begin
					warn_cnt_reg <= 10'h000;
					warn_sub_reg <= 4'h0;
					if (over_level) begin
						warn_state_reg <= ctrl_reg[CTRL_WARN_MODE] ? WARN_WAIT : WARN_ON;
					end
				end
				WARN_WAIT: begin
					if (!over_level) begin
						warn_state_reg <= WARN_IDLE;
					end else if (warn_cnt_reg >= warn_delay_reg) begin
						warn_state_reg <= WARN_ON;
					end else if (tick_reg) begin
						if (warn_sub_reg == 4'(DELAY_TICKS - 1)) begin
							warn_sub_reg <= 4'h0;
							warn_cnt_reg <= warn_cnt_reg + 10'h001;
						end else begin
							warn_sub_reg <= warn_sub_reg + 4'h1;
						end
					end
				end
				WARN_ON: begin
					if (released) begin
						warn_state_reg <= WARN_IDLE;
					end
				end
				default: begin
					warn_state_reg <= WARN_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			overload_early_warning_o <= 1'b0;
		end else begin
			overload_early_warning_o <= (warn_state_reg == WARN_ON) && !ctrl_reg[CTRL_MOTOR2];
		end
	end

	// ------------------------------------------------------------
	// timed run
	// ------------------------------------------------------------
	logic [18:0] run_cnt_reg;
	logic        run_on;
	assign run_on = pin_sync_reg[4] & ~pin_sync_reg[5];

	// power loss is the reset itself
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || !run_on || !ctrl_reg[CTRL_TIMED_RUN]) begin
			run_cnt_reg <= 19'h00000;
			auto_stop_o <= 1'b0;
		end else begin
			if (tick_reg && run_cnt_reg < stage_time_reg) begin
				run_cnt_reg <= run_cnt_reg + 19'h00001;
			end
			auto_stop_o <= (run_cnt_reg >= stage_time_reg);
		end
	end

	// ------------------------------------------------------------
	// analog offset and smoothing
	// ------------------------------------------------------------
	logic [10:0] ana_v_reg;
	logic [10:0] ana_i_reg;
	logic [8:0]  v_tau;
	logic [8:0]  i_tau;
	int          adj_v;
	int          adj_i;
	assign adj_v = clampi(int'(analog_v_i) + int'(ofs_v_reg), 0, ANA_FULL);
	assign adj_i = clampi(int'(analog_i_i) + int'(ofs_i_reg), 0, ANA_FULL);
	assign v_tau = ctrl_reg[CTRL_FB_ON_V] ? fb_filt_reg : ana_filt_reg;
	assign i_tau = ctrl_reg[CTRL_FB_ON_I] ? fb_filt_reg : ana_filt_reg;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ana_v_reg <= 11'h000;
			ana_i_reg <= 11'h000;
		end else begin
			if (tick_reg || v_tau == 9'h000) begin
				ana_v_reg <= 11'(lpf(adj_v, int'(ana_v_reg), int'(v_tau)));
			end
			if (tick_reg || i_tau == 9'h000) begin
				ana_i_reg <= 11'(lpf(adj_i, int'(ana_i_reg), int'(i_tau)));
			end
		end
	end

	// ------------------------------------------------------------
	// display values
	// ------------------------------------------------------------
	logic [14:0] disp_speed_reg;
	logic [15:0] disp_pid_reg;
	logic [11:0] disp_cur_reg;
	logic [15:0] disp_volt_reg;
	int          disp_n;
	assign disp_n = int'(disp_filt_reg) * DISP_TICKS;

	// product stays below 2^31 at full scale
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			disp_speed_reg <= 15'h0000;
			disp_pid_reg   <= 16'h0000;
		end else begin
			disp_speed_reg <= 15'(clampi(int'(out_freq_i) * int'(disp_a_reg) / (HZ_TO_CHZ * HZ_TO_CHZ),
				DISP_MIN, SCALE_MAX));
			disp_pid_reg   <= 16'(int'(pid_value_i) * (int'(disp_a_reg) - int'(disp_b_reg)) / PID_FULL
				+ int'(disp_b_reg));
		end
	end

	// flicker filter on current and voltage only
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			disp_cur_reg  <= 12'h000;
			disp_volt_reg <= 16'h0000;
		end else if (tick_reg || disp_n == 0) begin
			disp_cur_reg  <= 12'(lpf(int'(out_current_i), int'(disp_cur_reg), disp_n));
			disp_volt_reg <= 16'(lpf(int'(out_voltage_i), int'(disp_volt_reg), disp_n));
		end
	end

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic [31:0] rd_data;
	logic        rd_ok;
	always_comb begin
		rd_data = 32'h00000000;
		rd_ok   = 1'b1;
		if (paddr_i[1:0] != 2'b00) begin
			rd_ok = 1'b0;
		end else if (paddr_i == OFS_CTRL) begin
			rd_data = 32'(ctrl_reg);
		end else if (paddr_i == OFS_WARN_LEVEL) begin
			rd_data = 32'(warn_level_reg);
		end else if (paddr_i == OFS_WARN_DELAY) begin
			rd_data = 32'(warn_delay_reg);
		end else if (paddr_i == OFS_DISP_A) begin
			rd_data = 32'(disp_a_reg);
		end else if (paddr_i == OFS_DISP_B) begin
			rd_data = 32'(disp_b_reg);
		end else if (paddr_i == OFS_DISP_FILT) begin
			rd_data = 32'(disp_filt_reg);
		end else if (paddr_i == OFS_SKIP_1) begin
			rd_data = 32'(skip_reg[0]);
		end else if (paddr_i == OFS_SKIP_2) begin
			rd_data = 32'(skip_reg[1]);
		end else if (paddr_i == OFS_SKIP_3) begin
			rd_data = 32'(skip_reg[2]);
		end else if (paddr_i == OFS_SKIP_BW) begin
			rd_data = 32'(skip_bw_reg);
		end else if (paddr_i == OFS_STAGE_TIME) begin
			rd_data = 32'(stage_time_reg);
		end else if (paddr_i == OFS_ANA_OFS) begin
			rd_data = 32'({ofs_i_reg, ofs_v_reg});
		end else if (paddr_i == OFS_ANA_FILT) begin
			rd_data = 32'(ana_filt_reg);
		end else if (paddr_i == OFS_FB_FILT) begin
			rd_data = 32'(fb_filt_reg);
		end else if (paddr_i >= OFS_PRESET_0 && paddr_i <= OFS_PRESET_END) begin
			rd_data = 32'(preset_reg[preset_idx]);
		end else if (paddr_i == OFS_FREQ_REF) begin
			rd_data = 32'(freq_ref_o);
		end else if (paddr_i == OFS_STATUS) begin
			rd_data = {6'h00, warn_state_reg, run_cnt_reg, 3'h0, auto_stop_o, overload_early_warning_o};
		end else if (paddr_i == OFS_DISP_SPEED) begin
			rd_data = 32'(disp_speed_reg);
		end else if (paddr_i == OFS_DISP_PID) begin
			rd_data = 32'(disp_pid_reg);
		end else if (paddr_i == OFS_DISP_CUR) begin
			rd_data = 32'(disp_cur_reg);
		end else if (paddr_i == OFS_DISP_VOLT) begin
			rd_data = 32'(disp_volt_reg);
		end else if (paddr_i == OFS_ANA_V) begin
			rd_data = 32'(ana_v_reg);
		end else if (paddr_i == OFS_ANA_I) begin
			rd_data = 32'(ana_i_reg);
		end else begin
			rd_ok = 1'b0;
		end
	end

	// answer in the first access cycle; data captured at setup
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o  <= psel_i & ~penable_i;
			pslverr_o <= psel_i & ~penable_i & ~rd_ok;
			prdata_o  <= (psel_i & ~penable_i & ~pwrite_i & rd_ok) ? rd_data : 32'h00000000;
		end
	end

endmodule

`default_nettype wire

// File: frw_pkg.sv
package frw_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_MS = 10;
	localparam int TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int DELAY_UNIT_MS  = 100;
	localparam int DELAY_TICKS    = DELAY_UNIT_MS / TICK_PERIOD_MS;
	localparam int DISP_UNIT_MS   = 100;
	localparam int DISP_TICKS     = DISP_UNIT_MS / TICK_PERIOD_MS;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_WARN_LEVEL = 8'h04;
	localparam logic [7:0] OFS_WARN_DELAY = 8'h08;
	localparam logic [7:0] OFS_DISP_A     = 8'h0C;
	localparam logic [7:0] OFS_DISP_B     = 8'h10;
	localparam logic [7:0] OFS_DISP_FILT  = 8'h14;
	localparam logic [7:0] OFS_SKIP_1     = 8'h18;
	localparam logic [7:0] OFS_SKIP_2     = 8'h1C;
	localparam logic [7:0] OFS_SKIP_3     = 8'h20;
	localparam logic [7:0] OFS_SKIP_BW    = 8'h24;
	localparam logic [7:0] OFS_STAGE_TIME = 8'h28;
	localparam logic [7:0] OFS_ANA_OFS    = 8'h2C;
	localparam logic [7:0] OFS_ANA_FILT   = 8'h30;
	localparam logic [7:0] OFS_FB_FILT    = 8'h34;
	localparam logic [7:0] OFS_PRESET_0   = 8'h40;
	localparam logic [7:0] OFS_PRESET_END = 8'h78;
	localparam logic [7:0] OFS_FREQ_REF   = 8'h80;
	localparam logic [7:0] OFS_STATUS     = 8'h84;
	localparam logic [7:0] OFS_DISP_SPEED = 8'h88;
	localparam logic [7:0] OFS_DISP_PID   = 8'h8C;
	localparam logic [7:0] OFS_DISP_CUR   = 8'h90;
	localparam logic [7:0] OFS_DISP_VOLT  = 8'h94;
	localparam logic [7:0] OFS_ANA_V      = 8'h98;
	localparam logic [7:0] OFS_ANA_I      = 8'h9C;

	// ------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------
	localparam int CTRL_WARN_MODE  = 0;
	localparam int CTRL_TIMED_RUN  = 1;
	localparam int CTRL_MOTOR2     = 2;
	localparam int CTRL_FB_ON_V    = 3;
	localparam int CTRL_FB_ON_I    = 4;
	localparam int CTRL_ASSIGN_LSB = 8;
	localparam logic [11:0] CTRL_MASK = 12'hF1F;

	// ------------------------------------------------------------
	// setting limits and reset values
	// ------------------------------------------------------------
	localparam int LEVEL_MIN   = 20;
	localparam int LEVEL_MAX   = 200;
	localparam int LEVEL_RST   = 150;
	localparam int RELEASE_PCT = 90;
	localparam int DELAY_MIN   = 1;
	localparam int DELAY_MAX   = 600;
	localparam int DELAY_RST   = 100;
	localparam int SCALE_MAX   = 20000;
	localparam int SCALE_RST   = 100;
	localparam int DISP_MIN    = 1;
	localparam int DISP_FILT_MAX = 50;
	localparam int SKIP_MAX    = 400;
	localparam int SKIP_BW_MAX = 30;
	localparam int HZ_TO_CHZ   = 100;
	localparam int PRESET_MAX  = 40000;
	localparam int STAGE_MAX   = 360000;
	localparam int OFS_LIMIT   = 50;
	localparam int ANA_FULL    = 1000;
	localparam int ANA_FILT_MAX = 500;
	localparam int PID_FULL    = 10000;
	localparam int PCT_TO_PERMIL = 10;
	localparam int PRESETS     = 15;

	typedef enum logic [1:0] {
		WARN_IDLE  = 2'b00,
		WARN_WAIT  = 2'b01,
		WARN_ON    = 2'b10
	} frw_warn_t;

endpackage

// File: frw_term_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// terminal side: pin levels change only after a clock edge
// ------------------------------------------------------------
module frw_term_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] code_i,
	input  wire logic       run_i,
	input  wire logic       trip_i,
	output logic      [3:0] pins_o,
	output logic            run_o,
	output logic            trip_o
);
	// plain levels; an unassigned bit is dropped by the device mask
	always_ff @(posedge clk_i) begin
		pins_o <= code_i;
		run_o  <= run_i;
		trip_o <= trip_i;
	end
endmodule
`default_nettype wire

// File: frw_props.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module frw_props #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic        core_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        run_cmd_i,
	input wire logic        trip_i,
	input wire logic [11:0] out_current_i,
	input wire logic [11:0] thermal_level_i,
	input wire logic        overload_early_warning_o,
	input wire logic        auto_stop_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// zero-wait bus: ready only as the answer to a setup cycle
	a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready");
	a_ready_has_cause: assert property (pready_o |-> $past(psel_i) && !$past(penable_i)) else $error("stray ready");
	a_err_misaligned: assert property (psel_i && !penable_i && paddr_i[1:0] != 2'b00 |=> pslverr_o && pready_o)
		else $error("no error");
	a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h00000000) else $error("data outside access");
	a_outputs_reset: assert property ($fell(sys_rst_i) |-> !overload_early_warning_o && !auto_stop_o)
		else $error("output after reset");
	// margin covers the pin synchronisers
	a_stop_run_off: assert property (!run_cmd_i [*6] |-> !auto_stop_o) else $error("stop without run");
	a_stop_on_trip: assert property (trip_i [*6] |-> !auto_stop_o) else $error("stop during trip");
	a_warn_no_cause: assert property ((out_current_i <= 12'h0C8 && thermal_level_i <= 12'h0C8) [*6] |=>
		!$rose(overload_early_warning_o)) else $error("warning without cause");
	a_warn_release: assert property ((out_current_i < 12'h0B4 && thermal_level_i < 12'h0B4) [*6] |->
		!overload_early_warning_o) else $error("warning not released");
endmodule
bind frw_top frw_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .run_cmd_i(run_cmd_i), .trip_i(trip_i), .out_current_i(out_current_i),
	.thermal_level_i(thermal_level_i), .overload_early_warning_o(overload_early_warning_o),
	.auto_stop_o(auto_stop_o));
`default_nettype wire

// File: frw_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module frw_tb_top;
	import frw_pkg::*;
	logic        core_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, run_i, trip_i, ramping_i, e;
	logic        pready_o, pslverr_o, warn_o, stop_o, run_p, trip_p;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, q;
	logic [3:0]  code, pins;
	logic [15:0] normal_ref_i, out_freq_i, freq_ref_o;
	logic [11:0] out_current_i, thermal_level_i;
	logic [13:0] pid_value_i;
	int          err_count, n_compared, seed, pre[16];
	int          ca[8] = '{OFS_WARN_LEVEL, OFS_WARN_LEVEL, OFS_WARN_DELAY, OFS_WARN_DELAY, OFS_SKIP_1, OFS_SKIP_BW,
	                      OFS_PRESET_0, OFS_STAGE_TIME};
	int          cw[8] = '{10, 250, 0, 700, 500, 40, 50000, 400000};
	int          ce[8] = '{LEVEL_MIN, LEVEL_MAX, DELAY_MIN, DELAY_MAX, SKIP_MAX, SKIP_BW_MAX, PRESET_MAX, STAGE_MAX};

	frw_term_model u_term (.clk_i(core_clk_i), .code_i(code), .run_i(run_i), .trip_i(trip_i), .pins_o(pins),
		.run_o(run_p), .trip_o(trip_p));
	// short tick keeps every timed rule within a few hundred cycles
	frw_top #(.TICK_CYCLES(10)) DUT (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .step_select_bit0_i(pins[0]), .step_select_bit1_i(pins[1]),
		.step_select_bit2_i(pins[2]), .step_select_bit3_i(pins[3]), .run_cmd_i(run_p), .trip_i(trip_p),
		.ramping_i(ramping_i), .normal_ref_i(normal_ref_i), .out_freq_i(out_freq_i), .out_current_i(out_current_i),
		.thermal_level_i(thermal_level_i), .out_voltage_i(16'h0000), .analog_v_i(11'h000), .analog_i_i(11'h000),
		.pid_value_i(pid_value_i), .freq_ref_o(freq_ref_o), .overload_early_warning_o(warn_o), .auto_stop_o(stop_o));

	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic print_verdict();
		if (err_count == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// one transfer; request held until ready is sampled, then an idle edge
	task automatic apb(input logic wr, input int a, input int d);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= 8'(a);
		pwdata_i <= 32'(d);
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		chk("ready", pready_o, 1);
		if (n >= 16) print_verdict();
		@(posedge core_clk_i);
	endtask

	// one spare edge lets registered displays follow inputs set just before
	task automatic rdc(input string what, input int a, input int exp);
		@(posedge core_clk_i);
		apb(1'b0, a, 0);
		chk(what, q, 32'(exp));
	endtask

	// bounded wait for warning (0) or stop (1)
	task automatic wait_hi(input logic sel, input int max);
		int n;
		n = 0;
		while ((sel ? stop_o : warn_o) !== 1'b1 && n < max) begin
			@(posedge core_clk_i);
			n++;
		end
		chk("wait", sel ? stop_o : warn_o, 1);
		if (n >= max) print_verdict();
	endtask

	task automatic ref_is(input int exp);
		repeat (8) @(posedge core_clk_i);
		chk("freq_ref", freq_ref_o, 32'(exp));
	endtask

	initial begin
		seed = 32'hBCECCADB;
		{psel_i, penable_i, pwrite_i, run_i, trip_i, ramping_i, code, paddr_i, pwdata_i} = '0;
		{normal_ref_i, out_freq_i, out_current_i, thermal_level_i, pid_value_i} = '0;
		err_count = 0;
		n_compared = 0;
		sys_rst_i = 1'b1;
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge core_clk_i);
		rdc("ctrl", OFS_CTRL, 0);
		rdc("level", OFS_WARN_LEVEL, LEVEL_RST);
		rdc("delay", OFS_WARN_DELAY, DELAY_RST);
		apb(1'b0, 8'h3C, 0);
		chk("unmapped", e, 1);
		apb(1'b1, 8'h05, 7);
		chk("unaligned", e, 1);
		// settings beyond their ranges are clamped
		foreach (ca[i]) begin
			apb(1'b1, ca[i], cw[i]);
			rdc("clamp", ca[i], ce[i]);
		end
		apb(1'b1, OFS_SKIP_1, 0);
		apb(1'b1, OFS_SKIP_BW, 0);
		apb(1'b1, OFS_CTRL, 32'h00000F00);
		ramping_i <= 1'b1;
		for (int k = 1; k <= PRESETS; k++) begin
			pre[k] = $unsigned($random(seed)) % (PRESET_MAX + 1);
			apb(1'b1, OFS_PRESET_0 + 4 * (k - 1), pre[k]);
		end
		// every step code, random normal reference behind code zero
		for (int k = 0; k <= PRESETS; k++) begin
			pre[0] = $unsigned($random(seed)) % (PRESET_MAX + 1);
			normal_ref_i <= 16'(pre[0]);
			code <= 4'(k);
			ref_is(pre[k]);
		end
		apb(1'b1, OFS_CTRL, 32'h00000300);
		ref_is(pre[3]);
		code <= 4'h0;
		ramping_i <= 1'b0;
		normal_ref_i <= 16'd500;
		ref_is(500);
		apb(1'b1, OFS_SKIP_1, 10);
		apb(1'b1, OFS_SKIP_2, 14);
		apb(1'b1, OFS_SKIP_BW, 3);
		normal_ref_i <= 16'd1500;
		ref_is(1000 - 300);
		ramping_i <= 1'b1;
		ref_is(1500);
		ramping_i <= 1'b0;
		apb(1'b1, OFS_SKIP_1, 0);
		apb(1'b1, OFS_SKIP_2, 0);
		ref_is(1500);
		out_freq_i <= 16'd5000;
		rdc("speed", OFS_DISP_SPEED, 5000 * SCALE_RST / 10000);
		out_freq_i <= 16'd0;
		rdc("speed", OFS_DISP_SPEED, DISP_MIN);
		apb(1'b1, OFS_DISP_A, 20000);
		apb(1'b1, OFS_DISP_B, 1000);
		out_freq_i <= 16'd40000;
		pid_value_i <= 14'd5000;
		rdc("speed", OFS_DISP_SPEED, SCALE_MAX);
		rdc("pid", OFS_DISP_PID, 5000 * (20000 - 1000) / PID_FULL + 1000);
		apb(1'b1, OFS_STAGE_TIME, 5);
		apb(1'b1, OFS_CTRL, 32'h00000F02);
		run_i <= 1'b1;
		repeat (30) @(posedge core_clk_i);
		chk("stop early", stop_o, 0);
		wait_hi(1'b1, 60);
		run_i <= 1'b0;
		repeat (8) @(posedge core_clk_i);
		chk("stop cleared", stop_o, 0);
		trip_i <= 1'b1;
		run_i <= 1'b1;
		repeat (80) @(posedge core_clk_i);
		chk("stop in trip", stop_o, 0);
		trip_i <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h00000F00);
		repeat (80) @(posedge core_clk_i);
		chk("stop disabled", stop_o, 0);
		run_i <= 1'b0;
		apb(1'b1, OFS_WARN_LEVEL, 100);
		apb(1'b1, OFS_WARN_DELAY, 1);
		apb(1'b1, OFS_CTRL, 32'h00000F01);
		out_current_i <= 12'd1100;
		repeat (80) @(posedge core_clk_i);
		chk("warn early", warn_o, 0);
		wait_hi(1'b0, 60);
		out_current_i <= 12'd950;
		repeat (10) @(posedge core_clk_i);
		chk("warn held", warn_o, 1);
		out_current_i <= 12'd900;
		repeat (8) @(posedge core_clk_i);
		chk("warn released", warn_o, 0);
		apb(1'b1, OFS_CTRL, 32'h00000F05);
		out_current_i <= 12'd1100;
		repeat (200) @(posedge core_clk_i);
		chk("warn motor2", warn_o, 0);
		out_current_i <= 12'd0;
		thermal_level_i <= 12'd1100;
		apb(1'b1, OFS_CTRL, 32'h00000F00);
		wait_hi(1'b0, 8);
		print_verdict();
	end
endmodule
`default_nettype wire
